//--- usc_cfg.svh
/*
  Offsets, field positions, reset values and timing for the two-unit
  serial controller. Assumes it is included by bare name wherever used.
*/
`ifndef USC_CFG_SVH
`define USC_CFG_SVH

// Register indexes; byte address is four times the index
`define USC_IDX_W 8
`define USC_U0_CSR 8'h86
`define USC_U0_UCR 8'hC4
`define USC_U0_GCR 8'hC5
`define USC_U0_DBUF 8'hC6
`define USC_U0_RATE 8'hC7
`define USC_U1_CSR 8'h90
`define USC_U1_UCR 8'h91
`define USC_U1_GCR 8'h92
`define USC_U1_DBUF 8'h93
`define USC_U1_RATE 8'h94
`define USC_TIMER_CTRL_FLAG_REG 8'hA0
`define USC_IRQF2 8'hA1
`define USC_IRQ_ENABLE_REG_ZERO 8'hA2
`define USC_IRQ_ENABLE_REG_TWO 8'hA3

// Control/status fields
`define USC_CSR_MODE 7
`define USC_CSR_RXEN 6
`define USC_CSR_SLAVE 5
`define USC_CSR_FE 4
`define USC_CSR_ERR 3
`define USC_CSR_RXB 2
`define USC_CSR_TXB 1
`define USC_CSR_ACT 0

// UART control fields
`define USC_UCR_FLUSH 7
`define USC_UCR_D9 5
`define USC_UCR_BIT9 4
`define USC_UCR_PAR 3
`define USC_UCR_SPB 2
`define USC_UCR_STOP 1
`define USC_UCR_START 0
`define USC_UCR_RST 7'h02

`define USC_GCR_RST 8'h00
`define USC_RATE_RST 8'h00

// Clock cycles per bit for each rate step
`define USC_PRESCALE 16

`endif

//--- usc_pkg.sv
/*
  Types shared by the serial controller modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package usc_pkg;

  typedef enum logic [0:0]
  {
    usc_tx_idle = 1'b0,
    usc_tx_run = 1'b1
  } usc_tx_state_t;

  typedef enum logic [2:0]
  {
    usc_rx_idle = 3'b000,
    usc_rx_start = 3'b001,
    usc_rx_data = 3'b010,
    usc_rx_stop1 = 3'b011,
    usc_rx_stop2 = 3'b100
  } usc_rx_state_t;

endpackage

//--- usc_sync.sv
/*
  Two-flop synchroniser for one asynchronous level.
  Assumes the input is a pin with no relation to hclk.
*/
`timescale 1ns/100ps

module usc_sync
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic async_in, // Raw pin level
  input wire logic idle_lvl, // Unused; both flops reset high
  output logic sync_out // Synchronised level
);

  logic meta_reg;

  // First flop feeds only the second; reset to line idle (high)
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= 1'b1;
      sync_out <= 1'b1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

//--- usc_unit.sv
/*
  One serial unit: UART transmit and receive shifters, transmit holding
  byte, event pulses and busy. Assumes a synchronised receive line and
  configuration held steady while the unit is busy.
*/
`timescale 1ns/100ps
`include "usc_cfg.svh"

module usc_unit
#(
  parameter int PRESCALE = `USC_PRESCALE
)
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic flush, // Abort pulse
  input wire logic uart_mode, // Unit in UART mode
  input wire logic rx_en, // Receiver enabled
  input wire logic [6:0] ucr, // UART control fields
  input wire logic [7:0] rate, // Rate step
  input wire logic tx_load, // Data buffer written
  input wire logic [7:0] tx_data, // Byte to send
  input wire logic rxd_s, // Synchronised receive line
  output logic txd, // Transmit line
  output logic [7:0] rx_data, // Last received byte
  output logic rx_done, // Receive complete pulse
  output logic tx_start, // Transmit started pulse
  output logic tx_end, // Transmit finished pulse
  output logic frame_err, // Bad stop bit pulse
  output logic par_err, // Bad parity pulse
  output logic busy // Unit active
);

  if (PRESCALE < 2 || PRESCALE > 16)
    $error("usc_unit: PRESCALE must be 2 to 16");

  usc_pkg::usc_tx_state_t tx_state_reg;
  usc_pkg::usc_rx_state_t rx_state_reg;
  logic tx_pend_reg;
  logic [7:0] tx_hold_reg;
  logic [10:0] tx_frame_reg;
  logic [3:0] tx_left_reg;
  logic [12:0] tx_cnt_reg;
  logic [12:0] rx_cnt_reg;
  logic [3:0] rx_left_reg;
  logic [8:0] rx_sh_reg;

  wire logic [12:0] bit_cyc;
  wire logic [12:0] bit_last;
  wire logic start_lvl;
  wire logic stop_lvl;
  wire logic ninth;
  wire logic [7:0] rx_byte;
  wire logic par_bad;

  // Bit period from the rate step
  assign bit_cyc = ({5'h00, rate} + 13'h0001) * 13'(PRESCALE);
  assign bit_last = bit_cyc - 13'h0001;
  assign start_lvl = ucr[`USC_UCR_START];
  assign stop_lvl = ucr[`USC_UCR_STOP];
  assign ninth = ucr[`USC_UCR_PAR] ?
    (^tx_hold_reg) ^ ucr[`USC_UCR_D9] : ucr[`USC_UCR_D9];
  assign rx_byte = ucr[`USC_UCR_BIT9] ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
  assign par_bad = ucr[`USC_UCR_BIT9] && ucr[`USC_UCR_PAR] &&
    ((^rx_sh_reg) != ucr[`USC_UCR_D9]);
  assign busy = (tx_state_reg != usc_pkg::usc_tx_idle) ||
    (rx_state_reg != usc_pkg::usc_rx_idle);

  // Transmitter; holding byte makes the buffer double
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_state_reg <= usc_pkg::usc_tx_idle;
      tx_pend_reg <= 1'b0;
      tx_hold_reg <= 8'h00;
      tx_frame_reg <= 11'h000;
      tx_left_reg <= 4'h0;
      tx_cnt_reg <= 13'h0000;
      txd <= 1'b1;
      tx_start <= 1'b0;
      tx_end <= 1'b0;
    end
    else if (flush)
    begin
      tx_state_reg <= usc_pkg::usc_tx_idle;
      tx_pend_reg <= 1'b0;
      tx_hold_reg <= 8'h00;
      tx_frame_reg <= 11'h000;
      txd <= ~start_lvl;
      tx_start <= 1'b0;
      tx_end <= 1'b0;
    end
    else
    begin
      tx_start <= 1'b0;
      tx_end <= 1'b0;
      case (tx_state_reg)
        usc_pkg::usc_tx_idle:
        begin
          txd <= ~start_lvl;
          if (tx_pend_reg && uart_mode)
          begin
            tx_state_reg <= usc_pkg::usc_tx_run;
            tx_pend_reg <= 1'b0;
            tx_start <= 1'b1;
            txd <= start_lvl;
            tx_frame_reg <= {stop_lvl, stop_lvl,
              ucr[`USC_UCR_BIT9] ? ninth : stop_lvl, tx_hold_reg};
            tx_left_reg <= 4'd9 + {3'b000, ucr[`USC_UCR_BIT9]} +
              {3'b000, ucr[`USC_UCR_SPB]};
            tx_cnt_reg <= bit_last;
          end
        end
        usc_pkg::usc_tx_run:
        begin
          if (tx_cnt_reg != 13'h0000)
            tx_cnt_reg <= tx_cnt_reg - 13'h0001;
          else if (tx_left_reg == 4'h0)
          begin
            tx_state_reg <= usc_pkg::usc_tx_idle;
            tx_end <= 1'b1;
          end
          else
          begin
            txd <= tx_frame_reg[0];
            tx_frame_reg <= {1'b0, tx_frame_reg[10:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
            tx_cnt_reg <= bit_last;
          end
        end
        default: tx_state_reg <= usc_pkg::usc_tx_idle;
      endcase
      // A write lands after the idle check so it is never lost
      if (tx_load)
      begin
        tx_hold_reg <= tx_data;
        tx_pend_reg <= 1'b1;
      end
    end
  end

  // Receiver; samples mid-bit from the start edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_state_reg <= usc_pkg::usc_rx_idle;
      rx_cnt_reg <= 13'h0000;
      rx_left_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      rx_data <= 8'h00;
      rx_done <= 1'b0;
      frame_err <= 1'b0;
      par_err <= 1'b0;
    end
    else if (flush)
    begin
      rx_state_reg <= usc_pkg::usc_rx_idle;
      rx_sh_reg <= 9'h000;
      rx_data <= 8'h00;
      rx_done <= 1'b0;
      frame_err <= 1'b0;
      par_err <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      frame_err <= 1'b0;
      par_err <= 1'b0;
      if (rx_state_reg != usc_pkg::usc_rx_idle && rx_cnt_reg != 13'h0000)
        rx_cnt_reg <= rx_cnt_reg - 13'h0001;
      else
      begin
        case (rx_state_reg)
          usc_pkg::usc_rx_idle:
          begin
            if (uart_mode && rx_en && rxd_s == start_lvl)
            begin
              rx_state_reg <= usc_pkg::usc_rx_start;
              // Detect cycle counts too, so at two clocks a bit the
              // check still lands inside the start bit
              rx_cnt_reg <= {1'b0, bit_cyc[12:1]} - 13'h0001;
            end
          end
          usc_pkg::usc_rx_start:
          begin
            // A glitch shorter than half a bit is dropped
            if (rxd_s == start_lvl)
            begin
              rx_state_reg <= usc_pkg::usc_rx_data;
              rx_left_reg <= 4'd8 + {3'b000, ucr[`USC_UCR_BIT9]};
            end
            else
              rx_state_reg <= usc_pkg::usc_rx_idle;
            rx_cnt_reg <= bit_last;
          end
          usc_pkg::usc_rx_data:
          begin
            rx_sh_reg <= {rxd_s, rx_sh_reg[8:1]};
            rx_left_reg <= rx_left_reg - 4'h1;
            if (rx_left_reg == 4'h1)
              rx_state_reg <= usc_pkg::usc_rx_stop1;
            rx_cnt_reg <= bit_last;
          end
          usc_pkg::usc_rx_stop1:
          begin
            rx_data <= rx_byte;
            rx_done <= 1'b1;
            frame_err <= (rxd_s != stop_lvl);
            par_err <= par_bad;
            rx_cnt_reg <= bit_last;
            if (ucr[`USC_UCR_SPB] && rxd_s == stop_lvl)
              rx_state_reg <= usc_pkg::usc_rx_stop2;
            else
              rx_state_reg <= usc_pkg::usc_rx_idle;
          end
          usc_pkg::usc_rx_stop2:
          begin
            frame_err <= (rxd_s != stop_lvl);
            rx_state_reg <= usc_pkg::usc_rx_idle;
          end
          default: rx_state_reg <= usc_pkg::usc_rx_idle;
        endcase
      end
    end
  end

endmodule

//--- usc_top.sv
/*
  Two serial units behind an AHB-Lite slave: control/status, UART and
  generic control, data buffer, rate, interrupt flags and enables, and
  DMA triggers. Assumes one AHB master driving single word transfers and
  receive pins that are asynchronous to hclk.
*/
// Our own choice: the AHB-Lite interface to the registers.
// Summary of operation
// - Writing abort_clear stops that unit's transfers and empties its data buffers.
// - abort_clear is UART control bit 7, write-one, reads zero.
// - Two interrupt flags per unit: receive-complete and transmit-started.
// - Each flag has its own enable; request raised when both set.
// - Each unit has receive and transmit DMA triggers, four in all.
// - DMA trigger pulses on the flag-setting event regardless of enable.
// - Data buffer reads give received byte, writes load next byte.
// - Two identical units, each with five registers.
// - Status bit 7 picks SPI/UART, bit 5 master/slave, both reset zero.
// - Status bit 6 enables UART reception, reset zero.
// - Status bit 4 flags wrong stop bit, cleared by writing zero.
// - Receive flag and rx_ready_flag set at first stop bit, good or bad.
// - Bad second stop bit flags framing one bit after receive flag.
// - Status bit 3 flags parity failure, cleared by writing zero.
// - Status bit 1 set when each byte has been fully transmitted, even with another byte still pending.
// - Status bit 0 reads busy while transmitting or receiving.
`timescale 1ns/100ps
`include "usc_cfg.svh"

module usc_top
#(
  parameter int PRESCALE = `USC_PRESCALE
)
(
  input wire logic hclk, // System clock, 250 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [11:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Word transfers only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic [1:0] rxd, // Receive pins
  output logic [1:0] txd, // Transmit pins
  output logic [1:0] cpu_irq_rx, // Receive interrupt requests
  output logic [1:0] cpu_irq_tx, // Transmit interrupt requests
  output logic rx0_dma_trigger, // Unit 0 receive trigger
  output logic tx0_dma_trigger, // Unit 0 transmit trigger
  output logic rx1_dma_trigger, // Unit 1 receive trigger
  output logic tx1_dma_trigger // Unit 1 transmit trigger
);

  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [`USC_IDX_W-1:0] idx_reg;
  logic [1:0] rx_done_irq_flag;
  logic [1:0] tx_done_irq_flag;
  logic [1:0] rx_done_irq_en;
  logic [1:0] tx_done_irq_en;
  logic [1:0] rx_dma_reg;
  logic [1:0] tx_dma_reg;
  logic [1:0] rx_done_irq_flag_next;
  logic [1:0] tx_done_irq_flag_next;

  wire logic accept;
  wire logic idx_ok;
  wire logic wr_timer_ctrl_flag_reg;
  wire logic wr_irqf2;
  wire logic wr_irq_enable_reg_zero;
  wire logic wr_irq_enable_reg_two;
  wire logic [1:0] rx_done;
  wire logic [1:0] tx_start;
  wire logic [7:0] unit_rd [2];
  wire logic [7:0] glob_rd;
  wire logic [7:0] rd_mux;

  // Address phase taken when selected, active and the bus is ready
  assign accept = hsel && htrans[1] && hready;
  assign idx_ok = (haddr[11:10] == 2'b00) && (haddr[1:0] == 2'b00);
  assign wr_timer_ctrl_flag_reg = wr_pend_reg && idx_reg == `USC_TIMER_CTRL_FLAG_REG;
  assign wr_irqf2 = wr_pend_reg && idx_reg == `USC_IRQF2;
  assign wr_irq_enable_reg_zero = wr_pend_reg && idx_reg == `USC_IRQ_ENABLE_REG_ZERO;
  assign wr_irq_enable_reg_two = wr_pend_reg && idx_reg == `USC_IRQ_ENABLE_REG_TWO;

  // Shared interrupt registers; unmapped indexes read zero
  assign glob_rd =
    (idx_reg == `USC_TIMER_CTRL_FLAG_REG) ? {6'h00, rx_done_irq_flag} :
    (idx_reg == `USC_IRQF2) ? {6'h00, tx_done_irq_flag} :
    (idx_reg == `USC_IRQ_ENABLE_REG_ZERO) ? {6'h00, rx_done_irq_en} :
    (idx_reg == `USC_IRQ_ENABLE_REG_TWO) ? {6'h00, tx_done_irq_en} : 8'h00;
  assign rd_mux = glob_rd | unit_rd[0] | unit_rd[1];

  // Bus slave: writes with no wait, reads with one wait state so a
  // read right after a write sees the written value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= accept && hwrite;
      rd_pend_reg <= accept && !hwrite;
      if (accept)
        idx_reg <= idx_ok ? haddr[9:2] : 8'hFF;
      if (accept && !hwrite)
        hreadyout <= 1'b0;
      else if (rd_pend_reg)
      begin
        hreadyout <= 1'b1;
        hrdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Sticky flags; an event in the clearing cycle wins
  always_comb
  begin
    rx_done_irq_flag_next = rx_done | (rx_done_irq_flag &
      ~(wr_timer_ctrl_flag_reg ? ~hwdata[1:0] : 2'b00));
    tx_done_irq_flag_next = tx_start | (tx_done_irq_flag &
      ~(wr_irqf2 ? ~hwdata[1:0] : 2'b00));
  end

  // Flags, enables, requests and DMA pulses
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_done_irq_flag <= 2'b00;
      tx_done_irq_flag <= 2'b00;
      rx_done_irq_en <= 2'b00;
      tx_done_irq_en <= 2'b00;
      cpu_irq_rx <= 2'b00;
      cpu_irq_tx <= 2'b00;
      rx_dma_reg <= 2'b00;
      tx_dma_reg <= 2'b00;
    end
    else
    begin
      rx_done_irq_flag <= rx_done_irq_flag_next;
      tx_done_irq_flag <= tx_done_irq_flag_next;
      if (wr_irq_enable_reg_zero)
        rx_done_irq_en <= hwdata[1:0];
      if (wr_irq_enable_reg_two)
        tx_done_irq_en <= hwdata[1:0];
      cpu_irq_rx <= rx_done_irq_flag & rx_done_irq_en;
      cpu_irq_tx <= tx_done_irq_flag & tx_done_irq_en;
      rx_dma_reg <= rx_done;
      tx_dma_reg <= tx_start;
    end
  end

  // Trigger pins; each is its pulse register, one clock after the unit's event
  assign rx0_dma_trigger = rx_dma_reg[0];
  assign rx1_dma_trigger = rx_dma_reg[1];
  assign tx0_dma_trigger = tx_dma_reg[0];
  assign tx1_dma_trigger = tx_dma_reg[1];

  // Two identical units, five registers each
  for (genvar u = 0; u < 2; u++)
  begin : g_unit
    localparam logic [7:0] CSR_I = (u == 0) ? `USC_U0_CSR : `USC_U1_CSR;
    localparam logic [7:0] UCR_I = (u == 0) ? `USC_U0_UCR : `USC_U1_UCR;
    localparam logic [7:0] GCR_I = (u == 0) ? `USC_U0_GCR : `USC_U1_GCR;
    localparam logic [7:0] DBF_I = (u == 0) ? `USC_U0_DBUF : `USC_U1_DBUF;
    localparam logic [7:0] RAT_I = (u == 0) ? `USC_U0_RATE : `USC_U1_RATE;

    logic mode_reg;
    logic rx_enable_bit;
    logic slave_reg;
    logic framing_fault_flag;
    logic parity_fault_reg;
    logic rx_ready_flag;
    logic tx_byte_reg;
    logic [6:0] ucr_reg;
    logic [7:0] gcr_reg;
    logic [7:0] rate_reg;

    wire logic wr_csr;
    wire logic wr_ucr;
    wire logic flush;
    wire logic tx_load;
    wire logic rxd_s;
    wire logic busy;
    wire logic tx_end;
    wire logic frame_err;
    wire logic par_err;
    wire logic [7:0] rx_data;
    wire logic [7:0] csr_rd;
    wire logic [7:0] w0_clr;

    assign wr_csr = wr_pend_reg && idx_reg == CSR_I;
    assign wr_ucr = wr_pend_reg && idx_reg == UCR_I;
    assign flush = wr_ucr && hwdata[`USC_UCR_FLUSH];
    assign tx_load = wr_pend_reg && idx_reg == DBF_I;
    // Status bits cleared where a zero is written
    assign w0_clr = wr_csr ? ~hwdata[7:0] : 8'h00;
    assign csr_rd = {mode_reg, rx_enable_bit, slave_reg,
      framing_fault_flag, parity_fault_reg, rx_ready_flag,
      tx_byte_reg, busy};

    // Register read-back; abort bit always reads zero
    assign unit_rd[u] =
      (idx_reg == CSR_I) ? csr_rd :
      (idx_reg == UCR_I) ? {1'b0, ucr_reg} :
      (idx_reg == GCR_I) ? gcr_reg :
      (idx_reg == DBF_I) ? rx_data :
      (idx_reg == RAT_I) ? rate_reg : 8'h00;

    // Control bits and sticky status; hardware set beats software clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        mode_reg <= 1'b0;
        rx_enable_bit <= 1'b0;
        slave_reg <= 1'b0;
        framing_fault_flag <= 1'b0;
        parity_fault_reg <= 1'b0;
        rx_ready_flag <= 1'b0;
        tx_byte_reg <= 1'b0;
        ucr_reg <= `USC_UCR_RST;
        gcr_reg <= `USC_GCR_RST;
        rate_reg <= `USC_RATE_RST;
      end
      else
      begin
        if (wr_csr)
        begin
          mode_reg <= hwdata[`USC_CSR_MODE];
          rx_enable_bit <= hwdata[`USC_CSR_RXEN];
          slave_reg <= hwdata[`USC_CSR_SLAVE];
        end
        framing_fault_flag <= frame_err |
          (framing_fault_flag & ~w0_clr[`USC_CSR_FE]);
        parity_fault_reg <= par_err |
          (parity_fault_reg & ~w0_clr[`USC_CSR_ERR]);
        rx_ready_flag <= rx_done[u] |
          (rx_ready_flag & ~w0_clr[`USC_CSR_RXB]);
        tx_byte_reg <= tx_end |
          (tx_byte_reg & ~w0_clr[`USC_CSR_TXB]);
        if (wr_ucr)
          ucr_reg <= hwdata[6:0];
        if (wr_pend_reg && idx_reg == GCR_I)
          gcr_reg <= hwdata[7:0];
        if (wr_pend_reg && idx_reg == RAT_I)
          rate_reg <= hwdata[7:0];
      end
    end

    usc_sync u_sync
    (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(rxd[u]),
      .idle_lvl(1'b1),
      .sync_out(rxd_s)
    );

    usc_unit #(.PRESCALE(PRESCALE)) u_core
    (
      .hclk(hclk),
      .hresetn(hresetn),
      .flush(flush),
      .uart_mode(mode_reg),
      .rx_en(rx_enable_bit),
      .ucr(ucr_reg),
      .rate(rate_reg),
      .tx_load(tx_load),
      .tx_data(hwdata[7:0]),
      .rxd_s(rxd_s),
      .txd(txd[u]),
      .rx_data(rx_data),
      .rx_done(rx_done[u]),
      .tx_start(tx_start[u]),
      .tx_end(tx_end),
      .frame_err(frame_err),
      .par_err(par_err),
      .busy(busy)
    );
  end

endmodule

//--- usc_checker.sv
/*
  Port checker for usc_top.
  Assumes it is bound onto usc_top and sees only its ports.
*/
`timescale 1ns/100ps

module usc_checker
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Select
  input wire logic [11:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic [1:0] txd, // Transmit pins
  input wire logic [1:0] cpu_irq_rx, // Receive requests
  input wire logic [1:0] cpu_irq_tx, // Transmit requests
  input wire logic rx0_dma_trigger, // Unit 0 receive trigger
  input wire logic tx0_dma_trigger // Unit 0 transmit trigger
);
  logic [2:0] ph;
  wire take = hsel && htrans[1] && hready;

  // Data phase kind: read, write, write to unit 0 UART control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ph <= 3'h0;
    else if (hready)
      ph <= {take && !hwrite, take && hwrite,
        take && hwrite && haddr[9:2] == 8'hC4};
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_rdata_upper: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rx_event_pulse: assert property ($rose(rx0_dma_trigger) |=> !rx0_dma_trigger [*8])
    else $error("receive trigger too long");
  a_tx_event_pulse: assert property ($rose(tx0_dma_trigger) |=> !tx0_dma_trigger [*8])
    else $error("transmit trigger too long");
  a_abort_idle: assert property (ph[0] && hready && hwdata[7] && !hwdata[0]
    |=> (txd[0] && !tx0_dma_trigger && !rx0_dma_trigger) [*3])
    else $error("abort left unit running");
  a_irq_rx_held: assert property ($fell(cpu_irq_rx[0]) |-> $past(ph[1], 2))
    else $error("receive request dropped alone");
  a_irq_tx_held: assert property ($fell(cpu_irq_tx[0]) |-> $past(ph[1], 2))
    else $error("transmit request dropped alone");

  c_rx_event: cover property ($rose(rx0_dma_trigger));
  c_tx_event: cover property ($rose(tx0_dma_trigger));
  c_irq_rx: cover property ($rose(cpu_irq_rx[0]));
  c_abort: cover property (ph[0] && hready && hwdata[7]);
endmodule

bind usc_top usc_checker i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .txd, .cpu_irq_rx,
  .cpu_irq_tx, .rx0_dma_trigger, .tx0_dma_trigger);

//--- usc_peer.sv
/*
  UART peer on the far side of both units.
  Assumes low start bit, high idle, BIT clocks per bit.
*/
`timescale 1ns/100ps

module usc_peer
#(
  parameter int BIT = 2
)
(
  input wire logic hclk, // System clock
  input wire logic [1:0] txd, // Lines from the block
  output logic [1:0] rxd // Lines to the block
);
  logic [7:0] got; // Last byte seen on txd[0]
  int n_got = 0; // Frames seen

  initial rxd = 2'b11;

  // Send one frame LSB first; s holds the stop bits, nb the bit count
  task send(input int u, input logic [7:0] b, input logic [1:0] s,
    input int nb);
    logic [10:0] f;
    f = {s, b, 1'b0};
    for (int i = 0; i < nb; i++)
    begin
      rxd[u] <= f[i];
      repeat (BIT) @(posedge hclk);
    end
    rxd[u] <= 1'b1;
  endtask

  // Sample mid-bit, so edge skew between clocks never matters
  initial
  begin
    forever
    begin
      @(negedge txd[0]);
      repeat (BIT + BIT / 2) @(posedge hclk);
      for (int i = 0; i < 8; i++)
      begin
        got[i] = txd[0];
        repeat (BIT) @(posedge hclk);
      end
      n_got++;
    end
  end
endmodule

//--- usart_ctrl_status_events_test.sv
/*
  Self-checking bench for usc_top with a UART peer on both units.
  Assumes PRESCALE 2 and rate 0, so a bit lasts two clocks.
*/
`timescale 1ns/100ps

module usart_ctrl_status_events_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic rd_ph = 1'b0;
  logic [7:0] b;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int tests_run = 0;
  int seed = 32'h6E81;
  wire hreadyout, hresp, r0, t0, r1, t1;
  wire [31:0] hrdata;
  wire [1:0] rxd, txd, irx, itx;
  wire [3:0] ev = {t1, i_peer.n_got != 0, t0, r0};

  always #2 hclk = ~hclk;

  usc_top #(.PRESCALE(2)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd),
    .cpu_irq_rx(irx), .cpu_irq_tx(itx), .rx0_dma_trigger(r0),
    .tx0_dma_trigger(t0), .rx1_dma_trigger(r1), .tx1_dma_trigger(t1));
  usc_peer #(.BIT(2)) i_peer (.hclk(hclk), .txd(txd), .rxd(rxd));

  task cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Bounded wait for an edge with ready high
  task wt;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 40)
      begin
        err_count++;
        give_verdict;
      end
      @(posedge hclk);
    end
  endtask

  // Bounded wait for an event line
  task wev(input int k);
    int n;
    for (n = 0; n < 200 && ev[k] !== 1'b1; n++)
      @(posedge hclk);
    if (n == 200)
    begin
      err_count++;
      give_verdict;
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    haddr <= {2'h0, a, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    wt;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wt;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    xfer(1'b0, a, 8'h00);
  endtask

  // Request lines are read after the wait, not at the call
  task irq_is(input logic t, input logic [1:0] e);
    repeat (2) @(posedge hclk);
    cmp({30'h0, t ? itx : irx}, {30'h0, e});
  endtask

  // Match each finished read against the oldest note
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout === 1'b1)
      cmp(hrdata, exp_q.pop_front());
    if (hreadyout === 1'b1)
      rd_ph <= htrans[1] && !hwrite;
  end

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h86, 8'h00);
    rd(8'hC4, 8'h02);
    rd(8'h40, 8'h00);
    xfer(1'b1, 8'h86, 8'hE0);
    rd(8'h86, 8'hE0);
    xfer(1'b1, 8'h86, 8'hC0);
    $display("Done: registers");
    b = 8'($random(seed));
    fork
      i_peer.send(0, b, 2'h3, 10);
      wev(0);
    join
    rd(8'h86, 8'hC4);
    rd(8'hC6, b);
    rd(8'hA0, 8'h01);
    xfer(1'b1, 8'hA2, 8'h01);
    irq_is(1'b0, 2'h1);
    xfer(1'b1, 8'hA0, 8'h00);
    irq_is(1'b0, 2'h0);
    xfer(1'b1, 8'h86, 8'hC0);
    rd(8'h86, 8'hC0);
    fork
      i_peer.send(0, b, 2'h0, 10);
      wev(0);
    join
    xfer(1'b1, 8'h86, 8'hD4);
    rd(8'h86, 8'hD4);
    xfer(1'b1, 8'h86, 8'hC0);
    xfer(1'b1, 8'hC4, 8'h06);
    fork
      i_peer.send(0, b, 2'h1, 11);
      wev(0);
    join
    rd(8'h86, 8'hD4);
    xfer(1'b1, 8'hC4, 8'h02);
    xfer(1'b1, 8'h86, 8'hC0);
    $display("Done: receive");
    b = 8'($random(seed));
    fork
      xfer(1'b1, 8'hC6, b);
      wev(1);
    join
    wev(2);
    repeat (2) @(posedge hclk);
    cmp({24'h0, i_peer.got}, {24'h0, b});
    rd(8'h86, 8'hC2);
    rd(8'hA1, 8'h01);
    xfer(1'b1, 8'hA3, 8'h01);
    irq_is(1'b1, 2'h1);
    xfer(1'b1, 8'hA1, 8'h00);
    irq_is(1'b1, 2'h0);
    xfer(1'b1, 8'h86, 8'hC0);
    $display("Done: transmit");
    xfer(1'b1, 8'hC6, 8'($random(seed)));
    xfer(1'b1, 8'hC6, 8'($random(seed)));
    xfer(1'b1, 8'hC4, 8'h82);
    repeat (2) @(posedge hclk);
    xfer(1'b1, 8'hA1, 8'h00);
    rd(8'h86, 8'hC0);
    rd(8'hC4, 8'h02);
    rd(8'hC6, 8'h00);
    repeat (30) @(posedge hclk);
    rd(8'hA1, 8'h00);
    @(posedge hclk);
    $display("Done: abort");
    // Unit 1 transmit: own trigger, own flag bit, busy while sending
    xfer(1'b1, 8'h90, 8'h80);
    fork
      xfer(1'b1, 8'h93, b);
      wev(3);
    join
    rd(8'h90, 8'h81);
    rd(8'hA1, 8'h02);
    $display("Done: unit 1");
    give_verdict;
  end
endmodule
